// file: watchdog_pkg.sv
package watchdog_pkg;
  localparam logic [7:0] watchdog_control_addr = 8'he3;
  localparam logic [7:0] watchdog_control_reset = 8'h17;
  localparam logic [7:0] code_enable = 8'ha5;
  localparam logic [7:0] code_disable_first = 8'hde;
  localparam logic [7:0] code_disable_second = 8'had;
  localparam logic [7:0] code_lockout = 8'hff;
  localparam int status_bit = 4;
  localparam int update_guard_bit = 7;
  localparam logic [2:0] interval_reset = 3'h7;
  localparam int disable_window_clocks = 4;
  localparam logic [2:0] window_count_reset = 3'h0;
  localparam int base_timeout_bits = 8;
endpackage : watchdog_pkg

// file: watchdog_cnt_if.sv
`timescale 1ns/1ps
`default_nettype none
interface watchdog_cnt_if;
  logic run;
  logic reload;
  logic [2:0] interval;
  logic expire;
  modport ctrl (output run, output reload, output interval, input expire);
  modport cnt (input run, input reload, input interval, output expire);
endinterface : watchdog_cnt_if
`default_nettype wire

// file: watchdog_counter.sv
`timescale 1ns/1ps
`default_nettype none
module watchdog_counter
  import watchdog_pkg::*;
#(
  parameter int base_bits = base_timeout_bits
) (
  input wire logic mclk,
  input wire logic nrst,
  watchdog_cnt_if.cnt link
);
  localparam int cnt_w = base_bits + 7;
  logic [cnt_w-1:0] count;
  logic [cnt_w-1:0] limit;
  // interval n gives a period of 2^(base_bits+n) clocks
  assign limit = {cnt_w{1'b1}} >> (3'h7 - link.interval);
  always_ff @(posedge mclk) begin
    if (!nrst || link.reload || !link.run) begin
      count <= '0;
    end else if (count >= limit) begin
      count <= '0;
    end else begin
      count <= count + 1'b1;
    end
  end
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      link.expire <= 1'b0;
    end else begin
      link.expire <= link.run && !link.reload && (count >= limit);
    end
  end
endmodule : watchdog_counter
`default_nettype wire

// file: watchdog_control_unit.sv
`timescale 1ns/1ps
`default_nettype none
module watchdog_control_unit
  import watchdog_pkg::*;
#(
  parameter int base_bits = base_timeout_bits
) (
  input wire logic mclk,
  input wire logic nrst,
  input wire logic [7:0] sfr_addr,
  input wire logic sfr_wr,
  input wire logic sfr_rd,
  input wire logic [7:0] sfr_wdata,
  output logic [7:0] sfr_rdata,
  output logic watchdog_reset
);

  // disable sequence; locked is terminal until the next reset
  // one-hot, so a single flipped bit shows up as an illegal code
  typedef enum logic [2:0] {
    seq_idle = 3'b001,
    seq_armed = 3'b010,
    seq_locked = 3'b100
  } disable_seq_t;

  watchdog_cnt_if link ();

  // register access decode
  logic reg_hit;
  logic reg_read;
  logic wr_enable;
  logic wr_disable_first;
  logic wr_disable_second;
  logic wr_lockout;
  logic wr_interval;

  // control state and next values
  disable_seq_t seq_state;
  disable_seq_t next_seq_state;
  logic [2:0] window_count;
  logic [2:0] next_window_count;
  logic running;
  logic next_running;
  logic [2:0] timeout_interval_select;
  logic [2:0] next_timeout_interval_select;
  logic locked;
  logic window_open;
  logic disable_accept;
  logic [7:0] read_value;
  logic [7:0] next_sfr_rdata;

  assign reg_hit = sfr_wr && (sfr_addr == watchdog_control_addr);
  assign reg_read = sfr_rd && (sfr_addr == watchdog_control_addr);

  // every code is a whole-byte match, so only one strobe fires per write
  always_comb begin
    wr_enable = 1'b0;
    wr_disable_first = 1'b0;
    wr_disable_second = 1'b0;
    wr_lockout = 1'b0;
    wr_interval = 1'b0;
    if (reg_hit) begin
      wr_enable = (sfr_wdata == code_enable);
      wr_disable_first = (sfr_wdata == code_disable_first);
      wr_disable_second = (sfr_wdata == code_disable_second);
      wr_lockout = (sfr_wdata == code_lockout);
      wr_interval = !sfr_wdata[update_guard_bit];
    end
  end

  assign locked = (seq_state == seq_locked);
  assign window_open = (seq_state == seq_armed);

  assign disable_accept = wr_disable_second && window_open && !locked;

  // window_count holds the clocks left for the second disable code
  always_comb begin
    next_seq_state = seq_state;
    next_window_count = window_count;
    unique case (seq_state)
      seq_idle: begin
        if (wr_lockout) begin
          next_seq_state = seq_locked;
        end else if (wr_disable_first) begin
          next_seq_state = seq_armed;
          next_window_count = 3'(disable_window_clocks);
        end
      end
      seq_armed: begin
        if (wr_lockout) begin
          next_seq_state = seq_locked;
          next_window_count = window_count_reset;
        end else if (wr_disable_first) begin
          next_window_count = 3'(disable_window_clocks);
        end else if (reg_hit || window_count == 3'h1) begin
          // any other write to this register, or the last window clock, closes it
          next_seq_state = seq_idle;
          next_window_count = window_count_reset;
        end else begin
          next_window_count = window_count - 3'h1;
        end
      end
      seq_locked: begin
        next_window_count = window_count_reset;
      end
      // a corrupted code falls back to idle rather than hanging
      default: begin
        next_seq_state = seq_idle;
        next_window_count = window_count_reset;
      end
    endcase
  end

  always_comb begin
    next_running = running;
    // enable and disable codes differ, so both never fire together
    // enable starts it
    if (wr_enable) begin
      next_running = 1'b1;
    end else if (disable_accept) begin
      next_running = 1'b0;
    end
  end

  always_comb begin
    next_timeout_interval_select = timeout_interval_select;
    // the command codes have bit 7 set and leave the interval alone
    // low bits pick interval
    if (wr_interval) begin
      next_timeout_interval_select = sfr_wdata[2:0];
    end
  end

  // bits 7:5 and 3 have no function and read as zero
  always_comb begin
    read_value = 8'h00;
    read_value[status_bit] = running;
    read_value[2:0] = timeout_interval_select;
  end

  // data only stand for a matching read, so other addresses see zero
  always_comb begin
    next_sfr_rdata = 8'h00;
    if (reg_read) begin
      next_sfr_rdata = read_value;
    end
  end

  // state registers, one block per concern
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      seq_state <= seq_idle;
    end else begin
      seq_state <= next_seq_state;
    end
  end

  always_ff @(posedge mclk) begin
    if (!nrst) begin
      window_count <= window_count_reset;
    end else begin
      window_count <= next_window_count;
    end
  end

  always_ff @(posedge mclk) begin
    if (!nrst) begin
      running <= watchdog_control_reset[status_bit];
    end else begin
      running <= next_running;
    end
  end

  always_ff @(posedge mclk) begin
    if (!nrst) begin
      timeout_interval_select <= interval_reset;
    end else begin
      timeout_interval_select <= next_timeout_interval_select;
    end
  end

  always_ff @(posedge mclk) begin
    if (!nrst) begin
      sfr_rdata <= 8'h00;
    end else begin
      sfr_rdata <= next_sfr_rdata;
    end
  end

  // counter side of the link
  // reload counter
  assign link.reload = wr_enable;
  assign link.run = running;
  assign link.interval = timeout_interval_select;

  // registered so the reset request is a clean single-cycle pulse
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      watchdog_reset <= 1'b0;
    end else begin
      watchdog_reset <= link.expire;
    end
  end

  // the counter restarts itself after each expiry; software must
  // keep writing the enable code to hold the reset off
  watchdog_counter #(.base_bits(base_bits)) u_counter (
    .mclk(mclk),
    .nrst(nrst),
    .link(link)
  );
endmodule : watchdog_control_unit
`default_nettype wire

// file: wd_props.sv
`timescale 1ns/1ps
`default_nettype none
module wd_props #(parameter int base_bits = 8) (
  input wire logic mclk,
  input wire logic nrst,
  input wire logic [7:0] sfr_addr,
  input wire logic sfr_wr,
  input wire logic sfr_rd,
  input wire logic [7:0] sfr_wdata,
  input wire logic [7:0] sfr_rdata,
  input wire logic watchdog_reset
);
  wire logic w = sfr_wr && sfr_addr == 8'he3;
  wire logic r = sfr_rd && sfr_addr == 8'he3;
  logic [2:0] iv;
  logic lk;
  always_ff @(posedge mclk) iv <= !nrst ? 3'h7 : (w && !sfr_wdata[7]) ? sfr_wdata[2:0] : iv;
  always_ff @(posedge mclk) lk <= nrst && (lk || (w && sfr_wdata == 8'hff));
  default clocking @(posedge mclk); endclocking
  default disable iff (!nrst);
  sequence s_en; w && sfr_wdata == 8'ha5; endsequence
  sequence s_dis; w && sfr_wdata == 8'hde ##1 w && sfr_wdata == 8'had; endsequence
  property p_en; s_en ##1 r |=> sfr_rdata[4]; endproperty
  property p_dis; !lk ##0 s_dis ##1 r |=> !sfr_rdata[4]; endproperty
  // a fourth idle cycle puts the second code outside the window
  property p_win; s_en ##1 w && sfr_wdata == 8'hde ##1 !sfr_wr [*4] ##1 w && sfr_wdata == 8'had
    ##1 r |=> sfr_rdata[4]; endproperty
  property p_lock; lk ##0 s_en ##1 s_dis ##1 r |=> sfr_rdata[4]; endproperty
  property p_iv; r |=> sfr_rdata[2:0] == $past(iv); endproperty
  property p_idle; !r |=> sfr_rdata == 8'h0; endproperty
  property p_pulse; watchdog_reset |=> !watchdog_reset; endproperty
  property p_reload; s_en |-> ##2 !watchdog_reset ##1 !watchdog_reset; endproperty
  a_en: assert property (p_en) else $error("not running");
  a_dis: assert property (p_dis) else $error("not stopped");
  a_win: assert property (p_win) else $error("late stop");
  a_lock: assert property (p_lock) else $error("lock ignored");
  a_iv: assert property (p_iv) else $error("bad interval");
  a_idle: assert property (p_idle) else $error("stray data");
  a_pulse: assert property (p_pulse) else $error("long reset pulse");
  a_reload: assert property (p_reload) else $error("reset after reload");
endmodule : wd_props
`default_nettype wire

// file: tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic mclk = 0, nrst = 0, sfr_wr = 0, sfr_rd = 0, watchdog_reset;
  logic [7:0] sfr_addr = 8'h0, sfr_wdata = 8'h0, sfr_rdata;
  logic [7:0] sel[3] = '{8'ha5, 8'hde, 8'had};
  logic [31:0] d;
  int mismatches = 0, comparisons = 0, seed = 32'h1051, cyc = 0, run = 1, iv = 7, lk = 0, lc, lt;
  int pat[] = '{256, 8'hde, 8'had, 256, 8'ha5, 256, 3, 256, 8'h9a, 256, 8'hde, 512, 512, 512,
    8'had, 256, 8'ha5, 8'hde, 512, 512, 512, 512, 8'had, 256};
  int tail[] = '{8'hff, 8'ha5, 8'hde, 8'had, 256, 0, 256};
  int wc = 0, wrun = 1, wlk = 0, wiv = 7, wwin = 0, wx = 0, we = 0;
  logic whit;
  watchdog_control_unit #(.base_bits(2)) DUT (.mclk(mclk), .nrst(nrst), .sfr_addr(sfr_addr),
    .sfr_wr(sfr_wr), .sfr_rd(sfr_rd), .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata),
    .watchdog_reset(watchdog_reset));
  initial forever #2 mclk = ~mclk;
  always @(posedge mclk) cyc <= cyc + 1;
  task automatic summarize;
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : summarize
  task automatic cmp(input logic [7:0] seen, input logic [7:0] exp);
    comparisons++;
    if (seen !== exp) begin
      mismatches++;
      $display("MISMATCH sfr_rdata exp %h seen %h", exp, seen);
    end
  endtask : cmp
  task automatic cmp_reset(input logic seen, input logic exp);
    comparisons++;
    if (seen !== exp) begin
      mismatches++;
      $display("MISMATCH watchdog_reset exp %b seen %b", exp, seen);
    end
  endtask : cmp_reset
  // cycle model of the timeout path, fed with what the design samples
  always @(posedge mclk) begin
    if (nrst) cmp_reset(watchdog_reset, we[0]);
    whit = sfr_wr && sfr_addr == 8'he3;
    if (!nrst) begin
      wc = 0;
      wrun = 1;
      wlk = 0;
      wiv = 7;
      wwin = 0;
      wx = 0;
      we = 0;
    end else begin
      we = wx;
      wx = wrun && !(whit && sfr_wdata == 8'ha5) && wc >= (1 << (2 + wiv)) - 1;
      if (!wrun || (whit && sfr_wdata == 8'ha5) || wc >= (1 << (2 + wiv)) - 1) wc = 0;
      else wc++;
      if (whit && sfr_wdata == 8'had && wwin > 0 && !wlk) wrun = 0;
      if (whit && sfr_wdata == 8'ha5) wrun = 1;
      if (whit && sfr_wdata == 8'hff) wlk = 1;
      if (whit && !sfr_wdata[7]) wiv = sfr_wdata[2:0];
      if (whit) wwin = sfr_wdata == 8'hde ? 4 : 0;
      else if (wwin > 0) wwin--;
    end
  end
  task automatic op(input logic w, input logic r, input logic [7:0] a, input logic [7:0] v);
    @(posedge mclk);
    sfr_wr <= w;
    sfr_rd <= r;
    sfr_addr <= a;
    sfr_wdata <= v;
    if (w && a == 8'he3) begin
      if (v == 8'ha5) run = 1;
      if (v == 8'had && lc == 8'hde && cyc - lt <= 4 && !lk) run = 0;
      if (v == 8'hff) lk = 1;
      if (!v[7]) iv = v[2:0];
      lc = v;
      lt = cyc;
    end
    if (r) begin
      repeat (2) @(negedge mclk);
      cmp(sfr_rdata, a == 8'he3 ? {3'h0, run[0], 1'b0, iv[2:0]} : 8'h0);
    end
  endtask : op
  initial begin
    repeat (3) @(posedge mclk);
    nrst <= 1;
    foreach (pat[i]) op(pat[i] < 256, pat[i] == 256, 8'he3, pat[i][7:0]);
    repeat (150) begin
      d = $random(seed);
      op(d[9:8] != 0, d[9:8] == 0, d[10] ? 8'he3 : 8'he2,
        d[12:11] == 3 ? d[7:0] & 8'hfe : sel[d[12:11]]);
    end
    foreach (tail[i]) op(tail[i] < 256, tail[i] == 256, 8'he3, tail[i][7:0]);
    summarize();
  end
  initial begin
    #20000;
    mismatches++;
    summarize();
  end
endmodule : tb
bind watchdog_control_unit wd_props #(.base_bits(base_bits)) chk (.mclk(mclk), .nrst(nrst),
  .sfr_addr(sfr_addr), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd), .sfr_wdata(sfr_wdata),
  .sfr_rdata(sfr_rdata), .watchdog_reset(watchdog_reset));
`default_nettype wire
